// >>> nca_dev.sv
// Memory controller end: command registers, array, page buffer, read timing
//
// Overview of operation
// - Registers on peripheral path, memory on system path
// - Direct reads/buffer writes; erase and manual write by command
// - Command code written together with execution key
// - Ready low from accepted command until done
// - Commands while busy are discarded silently
// - Read data delayed by wait-state field
// - Main reads stall during main program/erase
// - Main reads proceed during EEPROM-area operations
// - EEPROM word reads take double data phase
// - EEPROM area unreadable while main busy
// - Requester does not erase before programming
// - Separate row erases; debugger chip erase clears both
// - Locked region refuses page write and row erase; debugger chip erase ignores the lock
// - Page buffer holds exactly one page
// - Byte writes to page buffer raise fault
// - Lock defaults load only at reset
// - Secondary control: power, wait states, write mode
`timescale 1ns/10ps
`default_nettype none
module nca_dev (
  input wire logic sys_clk,
  input wire logic rst_n,
  nca_if.dev bus
);
  typedef enum logic [1:0] {NCA_IDLE, NCA_MAIN_OP, NCA_EE_OP} nca_op_type;
  typedef enum logic [1:0] {NCA_RD_IDLE, NCA_RD_WAIT, NCA_RD_DONE} nca_rd_type;
  // All controller state
  typedef struct packed {
    nca_op_type op;
    logic [6:0] cmd;
    logic [7:0] op_cnt;
    logic ready;
    logic [31:0] sec_ctrl;
    logic [15:0] cmd_addr;
    logic [nca_pkg::REGION_W-1:0] lock;
    logic [nca_pkg::REGION_W-1:0] aux_lock;
    logic boot_load;
    nca_rd_type rd;
    logic rd_ee_word;
    logic [31:0] rdata;
    logic [31:0] pb_rdata;
    logic done;
    logic fault;
    logic [nca_pkg::PAGE_WORDS-1:0] buf_valid;
  } nca_dev_st_type;
  // Known power-up contents; the stored lock defaults are never cleared by reset
  nca_dev_st_type st_r = '0;
  nca_dev_st_type st_nxt;
  // Array storage and page buffer
  logic [31:0] main_mem [nca_pkg::MAIN_WORDS];
  logic [31:0] ee_mem [nca_pkg::EE_WORDS];
  logic [31:0] page_buf [nca_pkg::PAGE_WORDS];
  logic wait_start;
  logic [4:0] wait_cycles;
  logic wait_expired;
  logic in_main;
  logic in_ee;
  logic pb_hit;
  logic cmd_ok;
  logic [1:0] region;

  // Region number of a main-space byte address
  function automatic logic [1:0] region_of(input logic [15:0] a);
    region_of = a[9:8];
  endfunction

  // Wait-state counter shared by all reads
  nca_wait u_wait (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(wait_start),
    .cycles(wait_cycles),
    .expired(wait_expired)
  );

  // Address decode of the system path
  assign in_main = (bus.sb_addr >= nca_pkg::MAIN_BASE) && (bus.sb_addr < nca_pkg::MAIN_LIMIT);
  assign in_ee = (bus.sb_addr >= nca_pkg::EE_BASE) && (bus.sb_addr < nca_pkg::EE_LIMIT);
  assign region = region_of(st_r.cmd_addr);
  // Command accepted only with key and while ready
  assign cmd_ok = bus.pb_sel && bus.pb_write && (bus.pb_addr == nca_pkg::PRI_CTRL_OFS)
    && (bus.pb_wdata[nca_pkg::KEY_LSB +: 8] == nca_pkg::EXEC_KEY) && st_r.ready;
  // Buffer writes happen on the system path with no waiting
  // The done cycle is excluded so a request still up then is not answered twice
  assign pb_hit = bus.sb_req && bus.sb_write && (in_main || in_ee) && (st_r.rd == NCA_RD_IDLE)
    && !st_r.done;

  // Combinational next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.fault = 1'b0;
    st_nxt.boot_load = 1'b0;
    wait_start = 1'b0;
    wait_cycles = st_r.sec_ctrl[nca_pkg::RWS_LSB +: 4] + 5'h00;
    // Lock defaults enter the live lock only right after reset
    if (st_r.boot_load) begin
      st_nxt.lock = st_r.aux_lock;
    end
    // Peripheral register writes
    if (bus.pb_sel && bus.pb_write) begin
      if (bus.pb_addr == nca_pkg::SEC_CTRL_OFS) begin
        st_nxt.sec_ctrl = bus.pb_wdata;
      end else if (bus.pb_addr == nca_pkg::ADDR_OFS) begin
        st_nxt.cmd_addr = bus.pb_wdata[15:0];
      end else if (cmd_ok) begin
        st_nxt.cmd = bus.pb_wdata[nca_pkg::CMD_LSB +: 7];
        st_nxt.ready = 1'b0;
        st_nxt.op_cnt = 8'(nca_pkg::OP_CYCLES);
        if ((bus.pb_wdata[6:0] == nca_pkg::CMD_EE_ERASE_ROW)
            || (bus.pb_wdata[6:0] == nca_pkg::CMD_EE_WRITE_PAGE)) begin
          st_nxt.op = NCA_EE_OP;
        end else begin
          st_nxt.op = NCA_MAIN_OP;
        end
      end
    end
    // Debugger chip erase occupies the main array like a command
    if (bus.dbg_chip_erase && st_r.ready) begin
      st_nxt.cmd = nca_pkg::CMD_CHIP_ERASE;
      st_nxt.ready = 1'b0;
      st_nxt.op_cnt = 8'(nca_pkg::OP_CYCLES);
      st_nxt.op = NCA_MAIN_OP;
    end
    // Register read data
    if (bus.pb_addr == nca_pkg::PRI_CTRL_OFS) begin
      st_nxt.pb_rdata = {25'h0000000, st_r.cmd};
    end else if (bus.pb_addr == nca_pkg::SEC_CTRL_OFS) begin
      st_nxt.pb_rdata = st_r.sec_ctrl;
    end else if (bus.pb_addr == nca_pkg::FLAG_OFS) begin
      st_nxt.pb_rdata = {31'h00000000, st_r.ready};
    end else if (bus.pb_addr == nca_pkg::ADDR_OFS) begin
      st_nxt.pb_rdata = {16'h0000, st_r.cmd_addr};
    end else if (bus.pb_addr == nca_pkg::LOCK_OFS) begin
      st_nxt.pb_rdata = {28'h0000000, st_r.lock};
    end else begin
      st_nxt.pb_rdata = 32'h0000_0000;
    end
    // Command countdown
    case (st_r.op)
      NCA_IDLE: begin
      end
      default: begin
        st_nxt.op_cnt = st_r.op_cnt - 8'h01;
        if (st_r.op_cnt == 8'h01) begin
          st_nxt.op = NCA_IDLE;
          st_nxt.ready = 1'b1;
          if (st_r.cmd == nca_pkg::CMD_WRITE_AUX) begin
            st_nxt.aux_lock = page_buf[0][nca_pkg::REGION_W-1:0];
          end
          if (st_r.cmd == nca_pkg::CMD_CLEAR_BUF || st_r.cmd == nca_pkg::CMD_WRITE_PAGE
              || st_r.cmd == nca_pkg::CMD_EE_WRITE_PAGE) begin
            st_nxt.buf_valid = '0;
          end
        end
      end
    endcase
    // System path: writes land in the page buffer
    if (pb_hit) begin
      if (nca_size_ok(bus.sb_size)) begin
        st_nxt.buf_valid[bus.sb_addr[5:2]] = 1'b1;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.fault = 1'b1;
        st_nxt.done = 1'b1;
      end
    end
    // System path reads
    case (st_r.rd)
      NCA_RD_IDLE: begin
        if (bus.sb_req && !bus.sb_write && !st_r.done) begin
          if (in_main && st_r.op != NCA_MAIN_OP) begin
            st_nxt.rd = NCA_RD_WAIT;
            st_nxt.rd_ee_word = 1'b0;
            wait_start = 1'b1;
            st_nxt.rdata = main_mem[bus.sb_addr[9:2]];
          end else if (in_ee && st_r.op != NCA_MAIN_OP) begin
            st_nxt.rd = NCA_RD_WAIT;
            st_nxt.rd_ee_word = (bus.sb_size == nca_pkg::NCA_SZ_WORD);
            wait_start = 1'b1;
            st_nxt.rdata = ee_mem[bus.sb_addr[7:2]];
          end else if (!in_main && !in_ee) begin
            st_nxt.done = 1'b1;
            st_nxt.fault = 1'b1;
          end
        end
      end
      NCA_RD_WAIT: begin
        if (wait_expired) begin
          if (st_r.rd_ee_word) begin
            // Second pass of the counter doubles the data phase
            st_nxt.rd_ee_word = 1'b0;
            wait_start = 1'b1;
          end else begin
            st_nxt.rd = NCA_RD_DONE;
            st_nxt.done = 1'b1;
          end
        end
      end
      default: begin
        st_nxt.rd = NCA_RD_IDLE;
      end
    endcase
  end

  // Size check for page buffer writes
  function automatic logic nca_size_ok(input logic [1:0] sz);
    nca_size_ok = (sz != nca_pkg::NCA_SZ_BYTE);
  endfunction

  // State register; lock defaults reload one cycle after reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.ready <= 1'b1;
      st_r.sec_ctrl <= nca_pkg::SEC_CTRL_RST;
      st_r.boot_load <= 1'b1;
      st_r.aux_lock <= st_r.aux_lock;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Storage updates: buffer fill, program, erase
  always_ff @(posedge sys_clk) begin
    if (pb_hit && nca_size_ok(bus.sb_size)) begin
      page_buf[bus.sb_addr[5:2]] <= bus.sb_wdata;
    end
    if (bus.dbg_chip_erase && st_r.ready) begin
      for (int i = 0; i < nca_pkg::MAIN_WORDS; i++) main_mem[i] <= nca_pkg::ERASED_WORD;
      for (int i = 0; i < nca_pkg::EE_WORDS; i++) ee_mem[i] <= nca_pkg::ERASED_WORD;
    end else if (st_r.op != NCA_IDLE && st_r.op_cnt == 8'h01 && !st_r.lock[region]) begin
      for (int i = 0; i < nca_pkg::PAGE_WORDS; i++) begin
        if (st_r.cmd == nca_pkg::CMD_WRITE_PAGE && st_r.buf_valid[i]) begin
          // Programming only clears bits, so erased cells are needed first
          main_mem[{st_r.cmd_addr[9:6], 4'(i)}] <=
            main_mem[{st_r.cmd_addr[9:6], 4'(i)}] & page_buf[i];
        end
        if (st_r.cmd == nca_pkg::CMD_EE_WRITE_PAGE && st_r.buf_valid[i]) begin
          ee_mem[{st_r.cmd_addr[7:6], 4'(i)}] <= ee_mem[{st_r.cmd_addr[7:6], 4'(i)}] & page_buf[i];
        end
      end
      for (int i = 0; i < nca_pkg::ROW_WORDS; i++) begin
        if (st_r.cmd == nca_pkg::CMD_ERASE_ROW) begin
          main_mem[{st_r.cmd_addr[9:8], 6'(i)}] <= nca_pkg::ERASED_WORD;
        end
        if (st_r.cmd == nca_pkg::CMD_EE_ERASE_ROW) begin
          ee_mem[6'(i)] <= nca_pkg::ERASED_WORD;
        end
      end
    end
  end

  // Outputs straight from state flops
  assign bus.pb_rdata = st_r.pb_rdata;
  assign bus.sb_rdata = st_r.rdata;
  assign bus.sb_done = st_r.done;
  assign bus.sb_fault = st_r.fault;
endmodule
`default_nettype wire

// >>> nca_pkg.sv
// Shared constants and types for the memory command and access block
package nca_pkg;
  // Bus and address geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int PAGE_BYTES = 64;
  localparam int PAGE_WORDS = 16;
  localparam int ROW_WORDS = 64;
  localparam int MAIN_WORDS = 256;
  localparam int EE_WORDS = 64;
  localparam int REGION_W = 4;
  // Address windows (byte addresses)
  localparam logic [15:0] MAIN_BASE = 16'h0000;
  localparam logic [15:0] MAIN_LIMIT = 16'h0400;
  localparam logic [15:0] EE_BASE = 16'h4000;
  localparam logic [15:0] EE_LIMIT = 16'h4100;
  localparam logic [15:0] AUX_LOCK_ADDR = 16'h8000;
  // Peripheral register offsets
  localparam logic [7:0] PRI_CTRL_OFS = 8'h00;
  localparam logic [7:0] SEC_CTRL_OFS = 8'h04;
  localparam logic [7:0] FLAG_OFS = 8'h14;
  localparam logic [7:0] LOCK_OFS = 8'h20;
  localparam logic [7:0] ADDR_OFS = 8'h1C;
  // Primary control fields
  localparam logic [7:0] EXEC_KEY = 8'hA5;
  localparam int CMD_LSB = 0;
  localparam int KEY_LSB = 8;
  // Command codes
  localparam logic [6:0] CMD_ERASE_ROW = 7'h02;
  localparam logic [6:0] CMD_WRITE_PAGE = 7'h04;
  localparam logic [6:0] CMD_WRITE_AUX = 7'h06;
  localparam logic [6:0] CMD_EE_ERASE_ROW = 7'h1A;
  localparam logic [6:0] CMD_EE_WRITE_PAGE = 7'h1C;
  localparam logic [6:0] CMD_CLEAR_BUF = 7'h44;
  localparam logic [6:0] CMD_CHIP_ERASE = 7'h7F;
  // Secondary control fields and reset value
  localparam int RWS_LSB = 1;
  localparam int PWR_LSB = 8;
  localparam int MANW_BIT = 7;
  localparam logic [31:0] SEC_CTRL_RST = 32'h0000_0000;
  // Operation time in cycles
  localparam int OP_CYCLES = 20;
  localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;
  // Access size codes
  typedef enum logic [1:0] {NCA_SZ_BYTE, NCA_SZ_HALF, NCA_SZ_WORD} nca_size_type;
endpackage

// >>> nca_if.sv
// Interface joining the memory controller and its requester
`timescale 1ns/10ps
`default_nettype none
interface nca_if;
  // Peripheral (register) path
  logic pb_sel;
  logic pb_write;
  logic [7:0] pb_addr;
  logic [31:0] pb_wdata;
  logic [31:0] pb_rdata;
  // System (memory) path
  logic sb_req;
  logic sb_write;
  logic [1:0] sb_size;
  logic [15:0] sb_addr;
  logic [31:0] sb_wdata;
  logic [31:0] sb_rdata;
  logic sb_done;
  logic sb_fault;
  // Debugger chip erase
  logic dbg_chip_erase;
  modport dev (input pb_sel, pb_write, pb_addr, pb_wdata, output pb_rdata,
    input sb_req, sb_write, sb_size, sb_addr, sb_wdata, output sb_rdata,
    output sb_done, sb_fault, input dbg_chip_erase);
  modport req (output pb_sel, pb_write, pb_addr, pb_wdata, input pb_rdata,
    output sb_req, sb_write, sb_size, sb_addr, sb_wdata, input sb_rdata,
    input sb_done, sb_fault, output dbg_chip_erase);
endinterface
`default_nettype wire

// >>> nca_wait.sv
// Read wait-state counter: pulses when the programmed delay expires
`timescale 1ns/10ps
`default_nettype none
module nca_wait (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [4:0] cycles,
  output logic expired
);
  // Counter state
  typedef struct packed {
    logic busy;
    logic [4:0] cnt;
    logic done;
  } nca_wait_st_type;
  nca_wait_st_type st_r;
  nca_wait_st_type st_nxt;
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (start) begin
      // Zero delay still takes one cycle so data is registered
      st_nxt.busy = (cycles != 5'h00);
      st_nxt.cnt = cycles;
      st_nxt.done = (cycles == 5'h00);
    end else if (st_r.busy) begin
      st_nxt.cnt = st_r.cnt - 5'h01;
      if (st_r.cnt == 5'h01) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end
    end
  end
  // State register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign expired = st_r.done;
endmodule
`default_nettype wire

// >>> nca_req.sv
// Requester end: turns user operations into register and memory accesses
`timescale 1ns/10ps
`default_nettype none
module nca_req (
  input wire logic sys_clk,
  input wire logic rst_n,
  nca_if.req bus,
  input wire logic usr_go,
  input wire logic [1:0] usr_kind,
  input wire logic [6:0] usr_cmd,
  input wire logic [15:0] usr_addr,
  input wire logic [31:0] usr_wdata,
  input wire logic [1:0] usr_size,
  input wire logic usr_chip_erase,
  output logic usr_busy,
  output logic usr_done,
  output logic [31:0] usr_rdata,
  output logic usr_fault
);
  typedef enum logic [1:0] {NCA_Q_IDLE, NCA_Q_MEM, NCA_Q_POLL, NCA_Q_KEY} nca_q_type;
  // Requester state
  typedef struct packed {
    nca_q_type st;
    logic pb_sel;
    logic pb_write;
    logic [7:0] pb_addr;
    logic [31:0] pb_wdata;
    logic sb_req;
    logic sb_write;
    logic [1:0] sb_size;
    logic [15:0] sb_addr;
    logic [31:0] sb_wdata;
    logic chip;
    logic busy;
    logic done;
    logic fault;
    logic [31:0] rdata;
    logic [6:0] cmd;
    logic polled;
  } nca_req_st_type;
  nca_req_st_type st_r;
  nca_req_st_type st_nxt;
  // Next state: kind 0 read, 1 buffer write, 2 command, 3 register write
  always_comb begin
    st_nxt = st_r;
    st_nxt.pb_sel = 1'b0;
    st_nxt.pb_write = 1'b0;
    st_nxt.done = 1'b0;
    st_nxt.chip = usr_chip_erase && !st_r.busy;
    // Read data answers the previous cycle's access: remember a flag read
    st_nxt.polled = st_r.pb_sel && !st_r.pb_write && (st_r.pb_addr == nca_pkg::FLAG_OFS);
    case (st_r.st)
      NCA_Q_IDLE: begin
        if (usr_go) begin
          st_nxt.busy = 1'b1;
          st_nxt.fault = 1'b0;
          if (usr_kind[1] == 1'b0) begin
            st_nxt.st = NCA_Q_MEM;
            st_nxt.sb_req = 1'b1;
            st_nxt.sb_write = usr_kind[0];
            st_nxt.sb_addr = usr_addr;
            st_nxt.sb_wdata = usr_wdata;
            // Never issue byte writes to the page buffer
            st_nxt.sb_size = (usr_kind[0] && usr_size == nca_pkg::NCA_SZ_BYTE)
              ? nca_pkg::NCA_SZ_HALF : usr_size;
          end else if (usr_kind[0] == 1'b0) begin
            // Address first, then command with key in one later write
            st_nxt.st = NCA_Q_KEY;
            st_nxt.cmd = usr_cmd;
            st_nxt.pb_sel = 1'b1;
            st_nxt.pb_write = 1'b1;
            st_nxt.pb_addr = nca_pkg::ADDR_OFS;
            st_nxt.pb_wdata = {16'h0000, usr_addr};
          end else begin
            st_nxt.pb_sel = 1'b1;
            st_nxt.pb_write = 1'b1;
            st_nxt.pb_addr = usr_addr[7:0];
            st_nxt.pb_wdata = usr_wdata;
            st_nxt.busy = 1'b0;
            st_nxt.done = 1'b1;
          end
        end
      end
      NCA_Q_MEM: begin
        if (bus.sb_done) begin
          st_nxt.sb_req = 1'b0;
          st_nxt.rdata = bus.sb_rdata;
          st_nxt.fault = bus.sb_fault;
          st_nxt.busy = 1'b0;
          st_nxt.done = 1'b1;
          st_nxt.st = NCA_Q_IDLE;
        end
      end
      NCA_Q_KEY: begin
        // Code and key travel in one write
        st_nxt.st = NCA_Q_POLL;
        st_nxt.pb_sel = 1'b1;
        st_nxt.pb_write = 1'b1;
        st_nxt.pb_addr = nca_pkg::PRI_CTRL_OFS;
        st_nxt.pb_wdata = {16'h0000, nca_pkg::EXEC_KEY, 1'b0, st_r.cmd};
      end
      default: begin
        // Poll the ready flag until the operation is over
        st_nxt.pb_sel = 1'b1;
        st_nxt.pb_addr = nca_pkg::FLAG_OFS;
        if (st_r.polled && bus.pb_rdata[0]) begin
          st_nxt.pb_sel = 1'b0;
          st_nxt.busy = 1'b0;
          st_nxt.done = 1'b1;
          st_nxt.st = NCA_Q_IDLE;
        end
      end
    endcase
  end
  // State register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign bus.pb_sel = st_r.pb_sel;
  assign bus.pb_write = st_r.pb_write;
  assign bus.pb_addr = st_r.pb_addr;
  assign bus.pb_wdata = st_r.pb_wdata;
  assign bus.sb_req = st_r.sb_req;
  assign bus.sb_write = st_r.sb_write;
  assign bus.sb_size = st_r.sb_size;
  assign bus.sb_addr = st_r.sb_addr;
  assign bus.sb_wdata = st_r.sb_wdata;
  assign bus.dbg_chip_erase = st_r.chip;
  assign usr_busy = st_r.busy;
  assign usr_done = st_r.done;
  assign usr_rdata = st_r.rdata;
  assign usr_fault = st_r.fault;
endmodule
`default_nettype wire

// >>> nca_asserts.sv
// Concurrent checks on the signals between requester and memory controller
`timescale 1ns/10ps
`default_nettype none
module nca_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pb_sel,
  input wire logic pb_write,
  input wire logic [7:0] pb_addr,
  input wire logic [31:0] pb_wdata,
  input wire logic [31:0] pb_rdata,
  input wire logic sb_req,
  input wire logic sb_write,
  input wire logic [1:0] sb_size,
  input wire logic [15:0] sb_addr,
  input wire logic [31:0] sb_wdata,
  input wire logic [31:0] sb_rdata,
  input wire logic sb_done,
  input wire logic sb_fault,
  input wire logic dbg_chip_erase
);
  // Helper state: shadow of the busy window, wait states and read latency
  typedef struct packed {
    logic [4:0] main_cnt;
    logic [4:0] all_cnt;
    logic [1:0] quiet;
    logic [3:0] read_wait_states;
    logic [7:0] lat;
    logic idle_start;
    logic req_q;
  } nca_chk_type;
  nca_chk_type chk_r;
  nca_chk_type chk_nxt;
  // Keyed write to the primary control register
  wire key_cmd = pb_sel && pb_write && pb_addr == nca_pkg::PRI_CTRL_OFS
    && pb_wdata[15:8] == nca_pkg::EXEC_KEY;
  // Operations that occupy the main array
  wire main_op = dbg_chip_erase || (key_cmd && (pb_wdata[6:0] == nca_pkg::CMD_ERASE_ROW
    || pb_wdata[6:0] == nca_pkg::CMD_WRITE_PAGE));
  wire flag_rd = pb_sel && !pb_write && pb_addr == nca_pkg::FLAG_OFS;
  // Next helper state; a command during the window is not counted, as it must be dropped
  always_comb begin
    chk_nxt = chk_r;
    chk_nxt.req_q = sb_req;
    if (pb_sel && pb_write && pb_addr == nca_pkg::SEC_CTRL_OFS) begin
      chk_nxt.read_wait_states = pb_wdata[4:1];
    end
    if (chk_r.all_cnt != 5'd0) begin
      chk_nxt.all_cnt = chk_r.all_cnt - 5'd1;
    end
    if (chk_r.main_cnt != 5'd0) begin
      chk_nxt.main_cnt = chk_r.main_cnt - 5'd1;
    end
    if (chk_r.all_cnt == 5'd0 && (key_cmd || dbg_chip_erase)) begin
      chk_nxt.all_cnt = 5'd20;
      chk_nxt.main_cnt = main_op ? 5'd20 : 5'd0;
    end
    // Quiet saturates at 3 so the flag is only judged well clear of the edge
    if (chk_nxt.all_cnt != 5'd0) begin
      chk_nxt.quiet = 2'd0;
    end else if (chk_r.quiet != 2'd3) begin
      chk_nxt.quiet = chk_r.quiet + 2'd1;
    end
    if (sb_req && !chk_r.req_q) begin
      chk_nxt.lat = 8'd0;
      chk_nxt.idle_start = (chk_r.main_cnt == 5'd0);
    end else if (sb_req && chk_r.lat != 8'hFF) begin
      chk_nxt.lat = chk_r.lat + 8'd1;
    end
  end
  // Helper register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      chk_r <= '0;
    end else begin
      chk_r <= chk_nxt;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_read_start;
    $rose(sb_req) && !sb_write;
  endsequence
  sequence s_no_answer;
    !sb_done ##1 !sb_done;
  endsequence
  a_done_pulse: assert property (sb_done |=> !sb_done)
    else $error("memory done longer than one cycle");
  a_done_with_req: assert property (sb_done |-> sb_req)
    else $error("memory done without request");
  a_fault_at_done: assert property (sb_fault |-> sb_done)
    else $error("fault outside done");
  a_byte_fault: assert property ($rose(sb_req) && sb_write && sb_size == 2'd0
    |-> ##[1:4] (sb_done && sb_fault)) else $error("byte write not faulted");
  a_wide_write: assert property ($rose(sb_req) && sb_write && sb_size != 2'd0
    |-> ##[1:4] (sb_done && !sb_fault)) else $error("wide write refused");
  a_read_wait: assert property (s_read_start |-> s_no_answer)
    else $error("read answered too early");
  a_read_bound: assert property (s_read_start |-> ##[2:120] sb_done)
    else $error("read never answered");
  a_main_stall: assert property (sb_done && !sb_write && sb_addr < nca_pkg::MAIN_LIMIT
    |-> chk_r.main_cnt < 5'd3) else $error("main read during main operation");
  a_ee_stall: assert property (sb_done && !sb_write && sb_addr >= nca_pkg::EE_BASE
    && sb_addr < nca_pkg::EE_LIMIT |-> chk_r.main_cnt < 5'd3) else $error("area read early");
  a_no_stall: assert property (sb_done && !sb_write && sb_addr < nca_pkg::MAIN_LIMIT
    && chk_r.idle_start |-> chk_r.lat <= 8'd3 + {4'd0, chk_r.read_wait_states}) else $error("main read slow");
  a_busy_flag: assert property (flag_rd && chk_r.main_cnt >= 5'd3 |=> !pb_rdata[0])
    else $error("ready high during operation");
  a_ready_flag: assert property (flag_rd && chk_r.quiet == 2'd3 |=> pb_rdata[0])
    else $error("ready low while idle");
endmodule
`default_nettype wire

// >>> nvm_command_and_access_test.sv
// Self-checking bench: requester and controller joined over their interface
`timescale 1ns/10ps
`default_nettype none
module nvm_command_and_access_test;
  localparam logic [1:0] K_RD = 2'd0;
  localparam logic [1:0] K_BUF = 2'd1;
  localparam logic [1:0] K_CMD = 2'd2;
  localparam logic [1:0] K_REG = 2'd3;
  localparam logic [1:0] SZ_B = nca_pkg::NCA_SZ_BYTE;
  localparam logic [1:0] SZ_H = nca_pkg::NCA_SZ_HALF;
  localparam logic [1:0] SZ_W = nca_pkg::NCA_SZ_WORD;
  logic sys_clk;
  logic rst_n;
  logic go;
  logic chip_erase;
  logic [1:0] kind;
  logic [1:0] size;
  logic [6:0] cmd;
  logic [15:0] addr;
  logic [31:0] wdata;
  logic busy;
  logic done;
  logic fault;
  logic [31:0] rdata;
  int n_errors = 0;
  int n_checks = 0;
  int lat;
  int l0;
  int l2;
  int lh;
  nca_if bus_if();
  nca_dev nca_dev_inst (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus_if.dev));
  nca_req nca_req_inst (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus_if.req), .usr_go(go),
    .usr_kind(kind), .usr_cmd(cmd), .usr_addr(addr), .usr_wdata(wdata), .usr_size(size),
    .usr_chip_erase(chip_erase), .usr_busy(busy), .usr_done(done), .usr_rdata(rdata),
    .usr_fault(fault));
  nca_asserts nca_asserts_inst (.sys_clk(sys_clk), .rst_n(rst_n), .pb_sel(bus_if.pb_sel),
    .pb_write(bus_if.pb_write), .pb_addr(bus_if.pb_addr), .pb_wdata(bus_if.pb_wdata),
    .pb_rdata(bus_if.pb_rdata), .sb_req(bus_if.sb_req), .sb_write(bus_if.sb_write),
    .sb_size(bus_if.sb_size), .sb_addr(bus_if.sb_addr), .sb_wdata(bus_if.sb_wdata),
    .sb_rdata(bus_if.sb_rdata), .sb_done(bus_if.sb_done), .sb_fault(bus_if.sb_fault),
    .dbg_chip_erase(bus_if.dbg_chip_erase));
  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic summarize();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One user operation; lat counts cycles to its done pulse, bounded against hangs
  task automatic op(input logic [1:0] k, input logic [6:0] c, input logic [15:0] a,
    input logic [31:0] d, input logic [1:0] s);
    @(posedge sys_clk);
    {go, kind, cmd, addr, wdata, size} <= {1'b1, k, c, a, d, s};
    @(posedge sys_clk);
    go <= 1'b0;
    lat = 1;
    #1;
    while (done !== 1'b1 && lat < 300) begin
      @(posedge sys_clk);
      #1;
      lat++;
    end
    if (lat >= 300) check(32'h0, 32'h1);
  endtask
  // Command by register writes only: returns without waiting for ready
  task automatic kick(input logic [6:0] c, input logic [15:0] a);
    op(K_REG, 7'h0, {8'h0, nca_pkg::ADDR_OFS}, {16'h0, a}, SZ_W);
    op(K_REG, 7'h0, 16'h0000, {16'h0, nca_pkg::EXEC_KEY, 1'b0, c}, SZ_W);
  endtask
  // Watchdog, far beyond the expected run length
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    summarize();
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    {go, chip_erase, kind, cmd, addr, wdata, size} = '0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chip_erase <= 1'b1;
    @(posedge sys_clk);
    chip_erase <= 1'b0;
    #1;
    for (int i = 0; i < 100 && busy !== 1'b0; i++) @(posedge sys_clk);
    // Area read waits out the erase; then both spaces read erased
    op(K_RD, 7'h0, nca_pkg::EE_BASE, 32'h0, SZ_W);
    check(rdata, nca_pkg::ERASED_WORD);
    op(K_RD, 7'h0, 16'h0004, 32'h0, SZ_W);
    check(rdata, nca_pkg::ERASED_WORD);
    l0 = lat;
    // Two wait states stretch main and area half-word reads by two cycles
    op(K_REG, 7'h0, {8'h0, nca_pkg::SEC_CTRL_OFS}, 32'h0000_0004, SZ_W);
    op(K_RD, 7'h0, 16'h0004, 32'h0, SZ_W);
    check(32'(lat - l0), 32'h2);
    l2 = lat;
    op(K_RD, 7'h0, nca_pkg::EE_BASE, 32'h0, SZ_H);
    check(32'(lat), 32'(l2));
    lh = lat;
    op(K_RD, 7'h0, nca_pkg::EE_BASE, 32'h0, SZ_W);
    check({31'h0, lat > lh}, 32'h1);
    // Program, then program again without erase: bits only clear
    op(K_BUF, 7'h0, 16'h0000, 32'h1234_5678, SZ_W);
    op(K_CMD, nca_pkg::CMD_WRITE_PAGE, 16'h0000, 32'h0, SZ_W);
    op(K_RD, 7'h0, 16'h0000, 32'h0, SZ_W);
    check(rdata, 32'h1234_5678);
    op(K_BUF, 7'h0, 16'h0000, 32'h0000_FFFF, SZ_W);
    op(K_CMD, nca_pkg::CMD_WRITE_PAGE, 16'h0000, 32'h0, SZ_W);
    op(K_RD, 7'h0, 16'h0000, 32'h0, SZ_W);
    check(rdata, 32'h0000_5678);
    op(K_CMD, nca_pkg::CMD_ERASE_ROW, 16'h0000, 32'h0, SZ_W);
    op(K_RD, 7'h0, 16'h0000, 32'h0, SZ_W);
    check(rdata, nca_pkg::ERASED_WORD);
    // Byte requests go out as half words, so the buffer never faults
    op(K_BUF, 7'h0, 16'h0040, 32'h0000_0055, SZ_B);
    check({31'h0, fault}, 32'h0);
    op(K_BUF, 7'h0, 16'h0040, 32'h0000_00F0, SZ_H);
    check({31'h0, fault}, 32'h0);
    // Main reads run at full speed while the area is erased
    kick(nca_pkg::CMD_EE_ERASE_ROW, nca_pkg::EE_BASE);
    op(K_RD, 7'h0, 16'h0000, 32'h0, SZ_W);
    check(32'(lat), 32'(l2));
    repeat (25) @(posedge sys_clk);
    // Area reads stall while the main array is erased
    kick(nca_pkg::CMD_ERASE_ROW, 16'h0000);
    op(K_RD, 7'h0, nca_pkg::EE_BASE, 32'h0, SZ_H);
    check({31'h0, lat > lh}, 32'h1);
    // A keyed command while busy leaves no trace
    op(K_BUF, 7'h0, 16'h0100, 32'h0000_00F0, SZ_W);
    kick(nca_pkg::CMD_ERASE_ROW, 16'h0100);
    kick(nca_pkg::CMD_WRITE_PAGE, 16'h0100);
    op(K_RD, 7'h0, 16'h0100, 32'h0, SZ_W);
    check({31'h0, lat > l2}, 32'h1);
    check(rdata, nca_pkg::ERASED_WORD);
    // A command without the key is ignored
    op(K_REG, 7'h0, 16'h0000, {25'h0, nca_pkg::CMD_WRITE_PAGE}, SZ_W);
    op(K_RD, 7'h0, 16'h0100, 32'h0, SZ_W);
    check(rdata, nca_pkg::ERASED_WORD);
    // Region 0 lock default stored, live after a reset in mid-run
    op(K_BUF, 7'h0, 16'h0000, 32'h0000_0001, SZ_W);
    op(K_CMD, nca_pkg::CMD_WRITE_AUX, nca_pkg::AUX_LOCK_ADDR, 32'h0, SZ_W);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    op(K_BUF, 7'h0, 16'h0000, 32'h0, SZ_W);
    op(K_CMD, nca_pkg::CMD_WRITE_PAGE, 16'h0000, 32'h0, SZ_W);
    op(K_RD, 7'h0, 16'h0000, 32'h0, SZ_W);
    check(rdata, nca_pkg::ERASED_WORD);
    summarize();
  end
endmodule
`default_nettype wire
